// [common/smex_pkg.sv]
// shared types and constants of the shift / address / multiply-accumulate slice
// assumes: a 24-bit core, decoded instructions arriving from program control
package smex_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned ACC_W    = 56;
  localparam int unsigned STACK_AW = 4;

  // ****************************************************************
  // register map, byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_ACCA_LO = 8'h08;
  localparam logic [7:0] OFF_ACCA_HI = 8'h0C;
  localparam logic [7:0] OFF_ACCB_LO = 8'h10;
  localparam logic [7:0] OFF_ACCB_HI = 8'h14;
  localparam logic [7:0] OFF_STACK   = 8'h18;

  // field positions
  localparam int unsigned CTRL_DP_BIT    = 0;
  localparam int unsigned ST_C_BIT       = 0;
  localparam int unsigned ST_V_BIT       = 1;
  localparam int unsigned ST_Z_BIT       = 2;
  localparam int unsigned ST_N_BIT       = 3;
  localparam int unsigned ST_RANGE_BIT   = 4;
  localparam int unsigned ST_ILLEGAL_BIT = 5;
  localparam int unsigned ST_SP_LSB      = 8;

  // reset values
  localparam logic        DP_RST  = 1'b0;
  localparam logic [55:0] ACC_RST = 56'h0;
  localparam logic [3:0]  SP_RST  = 4'h0;

  // ****************************************************************
  // operation constants
  // ****************************************************************
  localparam logic [4:0]  IMM_MAX_LEFT  = 5'h10;
  localparam logic [4:0]  IMM_MAX_RIGHT = 5'h17;
  localparam logic [23:0] CNT_CLAMP     = 24'h000020;
  localparam logic [2:0]  PAIR_X0Y1     = 3'h4;
  localparam logic [2:0]  PAIR_X1Y0     = 3'h6;
  localparam logic [2:0]  PAIR_Y1X1     = 3'h7;

  typedef enum logic [3:0] {
    SMEX_OP_NONE, SMEX_OP_JUMP_SUBROUTINE_IF_BIT_ONE, SMEX_OP_LRA, SMEX_OP_LSL, SMEX_OP_LSR,
    SMEX_OP_LUA, SMEX_OP_LUA_DISP, SMEX_OP_MAC, SMEX_OP_MAC_IMM
  } smex_op_e;

  typedef enum logic [1:0] {SMEX_CNT_ONE, SMEX_CNT_IMM, SMEX_CNT_REG} smex_cnt_e;

  typedef enum logic [1:0] {
    SMEX_EA_REG_IND, SMEX_EA_ABS_SHORT, SMEX_EA_IO_SHORT, SMEX_EA_REG
  } smex_ea_e;

  typedef enum logic [2:0] {
    SMEX_UPD_INC1, SMEX_UPD_DEC1, SMEX_UPD_INCN, SMEX_UPD_DECN, SMEX_UPD_OTHER
  } smex_upd_e;

  typedef struct packed {
    smex_op_e    op;
    logic        acc_sel;
    logic        minus;
    smex_cnt_e   cnt_src;
    logic [4:0]  imm_cnt;
    logic [23:0] reg_cnt;
    logic [23:0] src1;
    logic [23:0] src2;
    logic [2:0]  pair;
    logic [4:0]  mac_n;
    smex_ea_e    ea_kind;
    logic [4:0]  bit_num;
    logic [23:0] test_word;
    logic [23:0] pc;
    logic [23:0] sr;
    logic [23:0] target;
    logic [23:0] disp;
    logic        dest_ssh;
    logic [23:0] addr_reg;
    logic [23:0] offset_reg;
    smex_upd_e   upd_mode;
    logic [6:0]  short_disp;
  } smex_instr_s;

  typedef struct packed {
    logic        dest_wr;
    logic [23:0] dest_val;
    logic        pc_wr;
    logic [23:0] pc_val;
    logic        rn_wr;
    logic        illegal;
  } smex_result_s;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } smex_ccr_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } smex_apb_req_s;

endpackage

// [hw/smex_stack_mem.sv]
// system stack store: two half-word lanes, registered read data
// assumes: one clock, synchronous active-low reset on the read register only
`timescale 1ns/1ps
`default_nettype none
module smex_stack_mem #(
  parameter int unsigned AW = 4,
  parameter int unsigned HW = 24
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // write port
  input  wire logic              wr_hi_i,
  input  wire logic              wr_lo_i,
  input  wire logic [AW-1:0]     waddr_i,
  input  wire logic [2*HW-1:0]   wdata_i,
  // read port
  input  wire logic [AW-1:0]     raddr_i,
  output logic      [2*HW-1:0]   rdata_o
);

  logic [2*HW-1:0] mem [2**AW];

  always_ff @(posedge core_clk_i) begin
    if (wr_hi_i) begin
      mem[waddr_i][2*HW-1:HW] <= wdata_i[2*HW-1:HW];
    end
    if (wr_lo_i) begin
      mem[waddr_i][HW-1:0] <= wdata_i[HW-1:0];
    end
  end

  // unwritten slots would read unknown, so the read register is reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

// [hw/smex_exec.sv]
// execution slice: bit-set subroutine jump, relative and updated address
// loads, logical shifts of the accumulator middle word, multiply-accumulate
// assumes: program control delivers one decoded instruction per valid cycle
// with operands already fetched; APB slave for control and observation
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module smex_exec #(
  parameter int unsigned STACK_AW = smex_pkg::STACK_AW
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // decoded instruction
  input  wire logic                   instr_valid_i,
  input  wire smex_pkg::smex_instr_s  instr_i,
  // results
  output smex_pkg::smex_result_s      res_o,
  output logic                        res_valid_o,
  output smex_pkg::smex_ccr_s         ccr_o,
  output logic [55:0]                 acc_a_o,
  output logic [55:0]                 acc_b_o,
  output logic [STACK_AW-1:0]         sp_o,
  // apb slave
  input  wire smex_pkg::smex_apb_req_s apb_i,
  output logic [31:0]                 prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [55:0]            acc_a_reg, acc_b_reg;
  logic [STACK_AW-1:0]    sp_reg;
  smex_pkg::smex_ccr_s    ccr_reg;
  smex_pkg::smex_result_s res_reg;
  logic                   res_valid_reg;
  logic                   dp_reg;
  logic                   range_err_reg;
  logic                   illegal_reg;
  logic [47:0]            stack_rdata;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire smex_pkg::smex_op_e op = instr_valid_i ? instr_i.op : smex_pkg::SMEX_OP_NONE;
  wire jump_subroutine_if_bit_one_go = (op == smex_pkg::SMEX_OP_JUMP_SUBROUTINE_IF_BIT_ONE);
  wire lra_go   = (op == smex_pkg::SMEX_OP_LRA);
  wire lsl_go   = (op == smex_pkg::SMEX_OP_LSL);
  wire lsr_go   = (op == smex_pkg::SMEX_OP_LSR);
  wire sh_go    = lsl_go | lsr_go;
  wire lua_go   = (op == smex_pkg::SMEX_OP_LUA);
  wire luad_go  = (op == smex_pkg::SMEX_OP_LUA_DISP);
  wire mac_go   = (op == smex_pkg::SMEX_OP_MAC) | (op == smex_pkg::SMEX_OP_MAC_IMM);
  wire [55:0] acc_cur = instr_i.acc_sel ? acc_b_reg : acc_a_reg;
  wire [23:0] mid     = acc_cur[47:24];

  // ****************************************************************
  // bit-set subroutine jump
  // ****************************************************************
  // every ea kind delivers its operand the same way here
  wire        bit_hit  = (instr_i.bit_num < 5'd24) && instr_i.test_word[instr_i.bit_num];
  wire        push_go  = jump_subroutine_if_bit_one_go & bit_hit;
  wire [23:0] ret_addr = instr_i.pc + 24'h000001;

  // ****************************************************************
  // address loads
  // ****************************************************************
  wire [23:0] lra_sum  = instr_i.pc + instr_i.disp;
  wire        ssh_go   = lra_go & instr_i.dest_ssh;
  wire [23:0] disp_ext = {{17{instr_i.short_disp[6]}}, instr_i.short_disp};
  wire [23:0] luad_sum = instr_i.addr_reg + disp_ext;
  logic [23:0] lua_val;
  logic        lua_ok;
  always_comb begin
    lua_ok  = 1'b1;
    lua_val = instr_i.addr_reg;
    case (instr_i.upd_mode)
      smex_pkg::SMEX_UPD_INC1: lua_val = instr_i.addr_reg + 24'h000001;
      smex_pkg::SMEX_UPD_DEC1: lua_val = instr_i.addr_reg - 24'h000001;
      smex_pkg::SMEX_UPD_INCN: lua_val = instr_i.addr_reg + instr_i.offset_reg;
      smex_pkg::SMEX_UPD_DECN: lua_val = instr_i.addr_reg - instr_i.offset_reg;
      default:                 lua_ok  = 1'b0;
    endcase
  end

  // ****************************************************************
  // logical shifts
  // ****************************************************************
  // counts above 32 clamp: the result is undefined past 24 anyway
  wire [23:0] cnt_raw = (instr_i.cnt_src == smex_pkg::SMEX_CNT_ONE) ? 24'h000001 :
                        (instr_i.cnt_src == smex_pkg::SMEX_CNT_IMM) ?
                        {19'h0, instr_i.imm_cnt} : instr_i.reg_cnt;
  wire [5:0]  cnt     = (cnt_raw > smex_pkg::CNT_CLAMP) ? 6'h20 : cnt_raw[5:0];
  wire [56:0] lwide   = {33'h0, mid} << cnt;
  wire [56:0] rwide   = {mid, 33'h0} >> cnt;
  wire [23:0] sh_res  = lsl_go ? lwide[23:0] : rwide[56:33];
  // right carry is taken just below bit 24
  wire        sh_last = lsl_go ? lwide[24] : rwide[32];
  wire        sh_c    = (cnt == 6'h00) ? 1'b0 : sh_last;
  wire [55:0] sh_acc  = {acc_cur[55:48], sh_res, acc_cur[23:0]};
  // immediate beyond its documented range still executes, flagged only
  wire        imm_out = (instr_i.cnt_src == smex_pkg::SMEX_CNT_IMM) &&
                        (instr_i.imm_cnt > (lsl_go ? smex_pkg::IMM_MAX_LEFT :
                                                     smex_pkg::IMM_MAX_RIGHT));

  // ****************************************************************
  // multiply-accumulate
  // ****************************************************************
  // in double precision mode the listed pairings take src1 unsigned
  wire        dp_pair = dp_reg && ((instr_i.pair == smex_pkg::PAIR_X0Y1) ||
                        (instr_i.pair == smex_pkg::PAIR_X1Y0) ||
                        (instr_i.pair == smex_pkg::PAIR_Y1X1));
  wire        s1_sign = dp_pair ? 1'b0 : instr_i.src1[23];
  wire signed [49:0] prod = $signed({s1_sign, instr_i.src1}) *
                            $signed({instr_i.src2[23], instr_i.src2});
  wire [55:0] term_mul = {{6{prod[49]}}, prod[48:0], 1'b0};
  wire [55:0] term_imm = 56'($signed({{8{instr_i.src1[23]}}, instr_i.src1, 24'h0})
                         >>> instr_i.mac_n);
  wire [55:0] term     = (op == smex_pkg::SMEX_OP_MAC_IMM) ? term_imm : term_mul;
  wire [55:0] addend   = instr_i.minus ? (56'h0 - term) : term;
  wire [55:0] mac_acc  = acc_cur + addend;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire apb_acc   = apb_i.psel & apb_i.penable;
  wire hit_ctrl  = (apb_i.paddr == smex_pkg::OFF_CTRL);
  wire hit_stat  = (apb_i.paddr == smex_pkg::OFF_STATUS);
  wire hit_alo   = (apb_i.paddr == smex_pkg::OFF_ACCA_LO);
  wire hit_ahi   = (apb_i.paddr == smex_pkg::OFF_ACCA_HI);
  wire hit_blo   = (apb_i.paddr == smex_pkg::OFF_ACCB_LO);
  wire hit_bhi   = (apb_i.paddr == smex_pkg::OFF_ACCB_HI);
  wire hit_stk   = (apb_i.paddr == smex_pkg::OFF_STACK);
  wire hit_any   = hit_ctrl | hit_stat | hit_alo | hit_ahi | hit_blo | hit_bhi | hit_stk;
  wire apb_wr    = apb_acc & apb_i.pwrite;
  wire [31:0] status_word = {16'h0, 8'(sp_reg), 2'b00, illegal_reg, range_err_reg,
                             ccr_reg.n, ccr_reg.z, ccr_reg.v, ccr_reg.c};
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~hit_any;
  assign prdata_o  = hit_ctrl ? {31'h0, dp_reg} :
                     hit_stat ? status_word :
                     hit_alo  ? acc_a_reg[31:0] :
                     hit_ahi  ? {8'h0, acc_a_reg[55:32]} :
                     hit_blo  ? acc_b_reg[31:0] :
                     hit_bhi  ? {8'h0, acc_b_reg[55:32]} :
                     hit_stk  ? {8'h0, stack_rdata[47:24]} : 32'h0;

  // ****************************************************************
  // next state
  // ****************************************************************
  wire        acc_wr   = sh_go | mac_go;
  wire [55:0] acc_new  = sh_go ? sh_acc : mac_acc;
  wire        wr_a_ins = acc_wr & ~instr_i.acc_sel;
  wire        wr_b_ins = acc_wr & instr_i.acc_sel;
  // an instruction write wins over a software write in the same cycle
  wire [55:0] acc_a_sw = hit_alo ? {acc_a_reg[55:32], apb_i.pwdata} :
                         {apb_i.pwdata[23:0], acc_a_reg[31:0]};
  wire [55:0] acc_b_sw = hit_blo ? {acc_b_reg[55:32], apb_i.pwdata} :
                         {apb_i.pwdata[23:0], acc_b_reg[31:0]};
  wire [55:0] acc_a_next = wr_a_ins ? acc_new :
                           (apb_wr & (hit_alo | hit_ahi)) ? acc_a_sw : acc_a_reg;
  wire [55:0] acc_b_next = wr_b_ins ? acc_new :
                           (apb_wr & (hit_blo | hit_bhi)) ? acc_b_sw : acc_b_reg;
  wire [STACK_AW-1:0] sp_next = (push_go | ssh_go) ? sp_reg + 1'b1 : sp_reg;
  wire smex_pkg::smex_ccr_s ccr_next = sh_go ?
         '{n: sh_res[23], z: (sh_res == 24'h0), v: 1'b0, c: sh_c} : ccr_reg;

  smex_pkg::smex_result_s res_next;
  always_comb begin
    res_next = '0;
    res_next.rn_wr = 1'b0;
    if (jump_subroutine_if_bit_one_go) begin
      res_next.pc_wr  = 1'b1;
      res_next.pc_val = push_go ? instr_i.target : ret_addr;
    end
    if (lra_go) begin
      res_next.dest_wr  = ~instr_i.dest_ssh;
      res_next.dest_val = lra_sum;
    end
    if (lua_go) begin
      res_next.dest_wr  = lua_ok;
      res_next.dest_val = lua_val;
      res_next.illegal  = ~lua_ok;
    end
    if (luad_go) begin
      res_next.dest_wr  = 1'b1;
      res_next.dest_val = luad_sum;
    end
  end

  // ****************************************************************
  // system stack
  // ****************************************************************
  smex_stack_mem #(.AW(STACK_AW), .HW(24)) u_stack (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_hi_i    (push_go | ssh_go),
    .wr_lo_i    (push_go),
    .waddr_i    (sp_next),
    .wdata_i    (push_go ? {ret_addr, instr_i.sr} : {lra_sum, 24'h0}),
    .raddr_i    (sp_reg),
    .rdata_o    (stack_rdata)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_a_reg <= smex_pkg::ACC_RST;
      acc_b_reg <= smex_pkg::ACC_RST;
      sp_reg    <= smex_pkg::SP_RST;
      ccr_reg   <= '0;
    end else begin
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      sp_reg    <= sp_next;
      ccr_reg   <= ccr_next;
    end
  end

  // sticky flags: a new event wins over a software clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res_reg       <= '0;
      res_valid_reg <= 1'b0;
      dp_reg        <= smex_pkg::DP_RST;
      range_err_reg <= 1'b0;
      illegal_reg   <= 1'b0;
    end else begin
      res_reg       <= res_next;
      res_valid_reg <= instr_valid_i;
      if (apb_wr & hit_ctrl) begin
        dp_reg <= apb_i.pwdata[smex_pkg::CTRL_DP_BIT];
      end
      range_err_reg <= (sh_go & imm_out) |
                       (range_err_reg & ~(apb_wr & hit_stat & apb_i.pwdata[smex_pkg::ST_RANGE_BIT]));
      illegal_reg   <= res_next.illegal |
                       (illegal_reg & ~(apb_wr & hit_stat & apb_i.pwdata[smex_pkg::ST_ILLEGAL_BIT]));
    end
  end

  assign res_o       = res_reg;
  assign res_valid_o = res_valid_reg;
  assign ccr_o       = ccr_reg;
  assign acc_a_o     = acc_a_reg;
  assign acc_b_o     = acc_b_reg;
  assign sp_o        = sp_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  // accumulator picked by the previous instruction, for flag checks
  logic        ccr_sel_q;
  logic [23:0] sh_acc_q;
  assign sh_acc_q = ccr_sel_q ? acc_b_reg[47:24] : acc_a_reg[47:24];
  always_ff @(posedge core_clk_i) begin
    ccr_sel_q <= instr_i.acc_sel;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_push_jump: assert property (push_go |=> res_o.pc_wr && sp_o == $past(sp_reg) + 1'b1
    && res_o.pc_val == $past(instr_i.target)) else $error("bit-set jump did not push and jump");
  a_skip_jump: assert property (jump_subroutine_if_bit_one_go && !bit_hit |=> sp_o == $past(sp_reg)
    && res_o.pc_val == $past(instr_i.pc) + 24'h000001) else $error("clear bit still jumped");
  a_lra_sum: assert property (lra_go && !instr_i.dest_ssh |=> res_o.dest_wr
    && res_o.dest_val == $past(instr_i.pc) + $past(instr_i.disp)) else $error("bad relative sum");
  a_ssh_incr: assert property (ssh_go |=> sp_o == $past(sp_reg) + 1'b1 && !res_o.dest_wr)
    else $error("stack pointer not bumped");
  a_zero_count: assert property (sh_go && cnt == 6'h00 |=> !ccr_o.c)
    else $error("zero count left carry set");
  a_lsl_one: assert property (lsl_go && cnt == 6'h01 && !instr_i.acc_sel
    |=> ccr_o.c == $past(acc_a_reg[47]) && acc_a_o[24] == 1'b0) else $error("one-bit left wrong");
  a_lsr_one: assert property (lsr_go && cnt == 6'h01
    |=> ccr_o.c == $past(acc_cur[24]) && !ccr_o.n) else $error("one-bit right wrong");
  a_shift_keep: assert property (sh_go && !instr_i.acc_sel |=>
    acc_a_o[55:48] == $past(acc_a_reg[55:48]) && acc_a_o[23:0] == $past(acc_a_reg[23:0]))
    else $error("shift touched bits outside middle");
  a_shift_flags: assert property (sh_go |=> !ccr_o.v && ccr_o.z == (sh_acc_q == 24'h0)
    && ccr_o.n == sh_acc_q[23]) else $error("shift flags wrong");
  a_lua_norn: assert property (lua_go && lua_ok |=> res_o.dest_wr && !res_o.rn_wr)
    else $error("updated load wrote source register");
  a_mac_plus: assert property (mac_go && !instr_i.minus
    |=> ($past(instr_i.acc_sel) ? acc_b_o : acc_a_o) == $past(acc_cur) + $past(term))
    else $error("accumulate wrong");
  a_mac_minus: assert property (mac_go && instr_i.minus && instr_i.acc_sel
    |=> acc_b_o == $past(acc_b_reg) - $past(term)) else $error("negated accumulate wrong");

  c_push: cover property (push_go ##1 push_go);
  c_long_left: cover property (lsl_go && cnt == 6'h10);
  c_mac_dp: cover property (mac_go && dp_pair);
  c_lua_bad: cover property (lua_go && !lua_ok);

endmodule
`default_nettype wire

// [tb/smex_feed.sv]
// partner model: program control issuing decoded instructions
// assumes: bench raises go_i one cycle before the instruction is due
`timescale 1ns/1ps
`default_nettype none
module smex_feed (
  // clock
  input  wire logic                  core_clk_i,
  // request from the bench
  input  wire logic                  go_i,
  input  wire smex_pkg::smex_instr_s in_i,
  // towards the slice
  output smex_pkg::smex_instr_s      instr_o,
  output logic                       valid_o
);
  initial begin
    valid_o = 1'b0;
    instr_o = '0;
  end
  // idle cycles scramble the operands so nothing leans on stale fields
  always @(posedge core_clk_i) begin
    valid_o <= go_i;
    instr_o <= go_i ? in_i : ~instr_o;
  end
endmodule
`default_nettype wire

// [tb/shift_addr_mac_exec_bench.sv]
// self-checking bench of the execution slice
// assumes: smex_exec and smex_feed compiled with the package
`timescale 1ns/1ps
`default_nettype none
module shift_addr_mac_exec_bench;
  logic                    core_clk_i, rst_n_i, go, vld, rv, pready, perr, err;
  smex_pkg::smex_instr_s   ins, din;
  smex_pkg::smex_apb_req_s apb;
  smex_pkg::smex_result_s  res;
  smex_pkg::smex_ccr_s     ccr;
  logic [55:0]             acc_a, acc_b;
  logic [3:0]              sp;
  logic [31:0]             prd, rd;
  int                      miscompares, checks, cycles;
  smex_feed feed (.core_clk_i(core_clk_i), .go_i(go), .in_i(ins), .instr_o(din), .valid_o(vld));
  smex_exec DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(vld), .instr_i(din),
    .res_o(res), .res_valid_o(rv), .ccr_o(ccr), .acc_a_o(acc_a), .acc_b_o(acc_b), .sp_o(sp),
    .apb_i(apb), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude;
    end
  end
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk_i);
    apb.penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prd;
    err = perr;
    apb <= '0;
  endtask
  task exec;
    @(posedge core_clk_i);
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(rv, 1'b1);
  endtask
  task sh(input smex_pkg::smex_op_e o, input smex_pkg::smex_cnt_e s, input logic [4:0] n,
          input logic [55:0] ea, input logic [3:0] ec);
    ins = '0;
    ins.op = o;
    ins.cnt_src = s;
    ins.imm_cnt = n;
    ins.reg_cnt = {19'h0, n};
    exec;
    chk(acc_a, ea);
    chk(ccr, ec);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task shifts;
    bus(1'b1, smex_pkg::OFF_ACCA_HI, 32'h0000F000);
    bus(1'b1, smex_pkg::OFF_ACCA_LO, 32'h01000000);
    sh(smex_pkg::SMEX_OP_LSL, smex_pkg::SMEX_CNT_IMM, 5'h04, 56'h00000010000000, 4'h1);
    sh(smex_pkg::SMEX_OP_LSR, smex_pkg::SMEX_CNT_REG, 5'h05, 56'h0, 4'h5);
    sh(smex_pkg::SMEX_OP_LSL, smex_pkg::SMEX_CNT_IMM, 5'h00, 56'h0, 4'h4);
    sh(smex_pkg::SMEX_OP_LSL, smex_pkg::SMEX_CNT_IMM, 5'h11, 56'h0, 4'h4);
    bus(1'b0, smex_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h00000014);
    bus(1'b1, smex_pkg::OFF_STATUS, 32'h00000010);
    bus(1'b0, smex_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h00000004);
    bus(1'b1, smex_pkg::OFF_ACCA_HI, 32'h00124000);
    bus(1'b1, smex_pkg::OFF_ACCA_LO, 32'h010000AB);
    sh(smex_pkg::SMEX_OP_LSL, smex_pkg::SMEX_CNT_ONE, 5'h00, 56'h128000020000AB, 4'h8);
    sh(smex_pkg::SMEX_OP_LSR, smex_pkg::SMEX_CNT_ONE, 5'h00, 56'h124000010000AB, 4'h0);
    sh(smex_pkg::SMEX_OP_LSR, smex_pkg::SMEX_CNT_IMM, 5'h01, 56'h122000000000AB, 4'h1);
  endtask
  task addr;
    logic [23:0] e [4];
    e = '{24'h000011, 24'h00000F, 24'h000015, 24'h00000B};
    ins = '0;
    ins.op = smex_pkg::SMEX_OP_LRA;
    ins.pc = 24'h000100;
    ins.disp = 24'hFFFFF0;
    exec;
    chk({res.dest_wr, res.dest_val}, {1'b1, 24'h0000F0});
    ins.dest_ssh = 1'b1;
    exec;
    chk(sp, 4'h1);
    ins = '0;
    ins.op = smex_pkg::SMEX_OP_LUA;
    ins.addr_reg = 24'h000010;
    ins.offset_reg = 24'h000005;
    for (int i = 0; i < 4; i++) begin
      ins.upd_mode = smex_pkg::smex_upd_e'(i);
      exec;
      chk({res.dest_wr, res.rn_wr, res.dest_val}, {2'b10, e[i]});
    end
    ins.upd_mode = smex_pkg::SMEX_UPD_OTHER;
    exec;
    chk({res.dest_wr, res.illegal}, 2'b01);
    bus(1'b0, smex_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h00000121);
    ins.op = smex_pkg::SMEX_OP_LUA_DISP;
    ins.short_disp = 7'h7E;
    exec;
    chk({res.dest_wr, res.rn_wr, res.dest_val}, {2'b10, 24'h00000E});
  endtask
  task jump;
    ins = '0;
    ins.op = smex_pkg::SMEX_OP_JUMP_SUBROUTINE_IF_BIT_ONE;
    ins.pc = 24'h000200;
    ins.target = 24'h00ABCD;
    ins.test_word = 24'h000008;
    ins.bit_num = 5'h03;
    for (int i = 0; i < 3; i++) begin
      ins.ea_kind = smex_pkg::smex_ea_e'(i);
      exec;
      chk({res.pc_wr, res.pc_val, sp}, {1'b1, 24'h00ABCD, 4'(i + 2)});
    end
    bus(1'b0, smex_pkg::OFF_STACK, 32'h0);
    chk(rd, 32'h00000201);
    ins.bit_num = 5'h02;
    exec;
    chk({res.pc_val, sp}, {24'h000201, 4'h4});
  endtask
  task mac;
    ins = '0;
    ins.op = smex_pkg::SMEX_OP_MAC;
    ins.acc_sel = 1'b1;
    ins.minus = 1'b1;
    ins.src1 = 24'h400000;
    ins.src2 = 24'h400000;
    exec;
    chk(acc_b, 56'hFFE00000000000);
    ins.minus = 1'b0;
    exec;
    chk(acc_b, 56'h0);
    ins.op = smex_pkg::SMEX_OP_MAC_IMM;
    ins.mac_n = 5'h01;
    exec;
    chk(acc_b, 56'h00200000000000);
    bus(1'b1, smex_pkg::OFF_CTRL, 32'h00000001);
    ins.op = smex_pkg::SMEX_OP_MAC;
    ins.pair = smex_pkg::PAIR_X0Y1;
    ins.src1 = 24'h800000;
    ins.src2 = 24'h000002;
    exec;
    chk(acc_b, 56'h00200002000000);
    bus(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask
  initial begin
    rst_n_i = 1'b0;
    go = 1'b0;
    ins = '0;
    apb = '0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({acc_a, sp}, 60'h0);
    shifts;
    addr;
    jump;
    mac;
    conclude;
  end
endmodule
`default_nettype wire
